// [pac_top.v]
`timescale 1ns/1ps
`include "pac_defines.vh"

module pac_top (
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RESETN_I,
  // Register port
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  // Reference and alignment pin
  input wire REF_INPUT_I,
  input wire ALIGN_PIN_I,
  // Results
  output reg ALIGN_PULSE_O,
  output reg CAL_START_O,
  output reg MOD_RESET_O,
  output reg [31:0] PHASE_ACC_O,
  output reg [31:0] PHASE_STEP_O,
  output wire [4:0] EXTRA_DIV_O
);

  reg [3:0] ctrl_r;
  reg [1:0] out_a_select_r;
  reg [1:0] out_b_select_r;
  reg [4:0] chan_div_select_r;
  reg [31:0] frac_denominator_r;
  reg [31:0] word_a_r;
  reg [31:0] seed_r;
  reg [1:0] mod_order_r;
  reg ref_d_r;
  reg pin_d_r;
  reg sw_req_r;
  reg seed_wr_r;
  reg [31:0] seed_wdata_r;
  reg [31:0] rdata_nxt;
  reg pin_req;
  reg seed_ok;
  wire ref_rise;
  wire align_retimed;
  wire [9:0] total_div;
  wire align_mode;
  wire disregard;
  wire freq_cal_enable;

  assign align_mode = ctrl_r[`PAC_CTRL_ALIGN_BIT];
  assign disregard = ctrl_r[`PAC_CTRL_DISREGARD_BIT];
  assign freq_cal_enable = ctrl_r[`PAC_CTRL_FCAL_BIT];
  assign ref_rise = REF_INPUT_I & ~ref_d_r;

  pac_extdiv u_extdiv (
    .out_a_select_i(out_a_select_r),
    .out_b_select_i(out_b_select_r),
    .chan_div_select_i(chan_div_select_r),
    .extra_div_o(EXTRA_DIV_O),
    .total_div_o(total_div)
  );

  pac_retime u_retime (
    .clk_i(CLK_SYS_I),
    .resetn_i(RESETN_I),
    .req_i(sw_req_r | pin_req),
    .ref_rise_i(ref_rise),
    .pulse_o(align_retimed)
  );

  // Pin rising edge counts only with calibration enabled and the disregard bit clear
  always @* begin
    pin_req = ALIGN_PIN_I & ~pin_d_r;
    pin_req = pin_req & freq_cal_enable & ~disregard;
  end

  // Seed step is usable for the present modulator settings
  always @* begin
    seed_ok = 1'b1;
    if (mod_order_r == 2'h0) begin
      seed_ok = 1'b0;
    end else if (mod_order_r == 2'h1 && frac_denominator_r != 32'h0) begin
      seed_ok = ((seed_wdata_r % frac_denominator_r) == 32'h0);
    end
  end

  // Register writes
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      ctrl_r <= `PAC_CTRL_RESET;
      out_a_select_r <= `PAC_MUX_VCO;
      out_b_select_r <= `PAC_MUX_VCO;
      chan_div_select_r <= 5'h00;
      frac_denominator_r <= 32'h1;
      word_a_r <= 32'h0;
      seed_r <= 32'h0;
      mod_order_r <= 2'h0;
      sw_req_r <= 1'b0;
      seed_wr_r <= 1'b0;
      seed_wdata_r <= 32'h0;
    end else begin
      sw_req_r <= 1'b0;
      seed_wr_r <= 1'b0;
      ctrl_r[`PAC_CTRL_MODRST_BIT] <= 1'b0;
      if (WR_I) begin
        case (ADDR_I)
          `PAC_ADDR_CTRL: begin
            ctrl_r <= WDATA_I[3:0];
            // Only a 0-to-1 change is a request
            sw_req_r <= WDATA_I[`PAC_CTRL_ALIGN_BIT] &
                        ~align_mode;
          end
          `PAC_ADDR_OUTSEL: begin
            out_a_select_r <= WDATA_I[1:0];
            out_b_select_r <= WDATA_I[5:4];
          end
          `PAC_ADDR_CHAN_DIV_SELECT: begin
            if (WDATA_I[4:0] <= `PAC_CHAN_DIV_SELECT_MAX) begin
              chan_div_select_r <= WDATA_I[4:0];
            end
          end
          `PAC_ADDR_DEN: frac_denominator_r <= WDATA_I;
          `PAC_ADDR_NUM: word_a_r <= WDATA_I;
          `PAC_ADDR_SEED: begin
            seed_r <= WDATA_I;
            seed_wr_r <= 1'b1;
            seed_wdata_r <= WDATA_I;
          end
          `PAC_ADDR_ORDER: mod_order_r <= WDATA_I[1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Edge detectors and phase accumulation
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      ref_d_r <= 1'b0;
      pin_d_r <= 1'b0;
      ALIGN_PULSE_O <= 1'b0;
      CAL_START_O <= 1'b0;
      MOD_RESET_O <= 1'b0;
      PHASE_ACC_O <= 32'h0;
      PHASE_STEP_O <= 32'h0;
    end else begin
      ref_d_r <= REF_INPUT_I;
      pin_d_r <= ALIGN_PIN_I;
      ALIGN_PULSE_O <= align_retimed;
      CAL_START_O <= align_retimed & freq_cal_enable;
      MOD_RESET_O <= ctrl_r[`PAC_CTRL_MODRST_BIT];
      // Phase in units of 1/(denominator*channel divide) turns
      PHASE_STEP_O <= seed_wdata_r * {27'h0, EXTRA_DIV_O};
      if (align_retimed || ctrl_r[`PAC_CTRL_MODRST_BIT]) begin
        PHASE_ACC_O <= 32'h0;
      end else if (seed_wr_r && seed_ok) begin
        PHASE_ACC_O <= PHASE_ACC_O +
          seed_wdata_r * {27'h0, EXTRA_DIV_O};
      end
    end
  end

  // Register reads
  always @* begin
    rdata_nxt = 32'h0;
    case (ADDR_I)
      `PAC_ADDR_CTRL: rdata_nxt = {28'h0, ctrl_r};
      `PAC_ADDR_OUTSEL: rdata_nxt = {26'h0, out_b_select_r, 2'h0,
                                     out_a_select_r};
      `PAC_ADDR_CHAN_DIV_SELECT: rdata_nxt = {22'h0, total_div};
      `PAC_ADDR_DEN: rdata_nxt = frac_denominator_r;
      `PAC_ADDR_NUM: rdata_nxt = word_a_r;
      `PAC_ADDR_SEED: rdata_nxt = seed_r;
      `PAC_ADDR_ORDER: rdata_nxt = {30'h0, mod_order_r};
      `PAC_ADDR_STATUS: rdata_nxt = {27'h0, chan_div_select_r};
      `PAC_ADDR_PHASE: rdata_nxt = PHASE_ACC_O;
      `PAC_ADDR_EXTDIV: rdata_nxt = {27'h0, EXTRA_DIV_O};
      default: rdata_nxt = 32'h0;
    endcase
  end

  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 32'h0;
    end else if (RD_I) begin
      RDATA_O <= rdata_nxt;
    end else begin
      RDATA_O <= 32'h0;
    end
  end

endmodule

// [pac_defines.vh]
`ifndef PAC_DEFINES_VH
`define PAC_DEFINES_VH

// Register byte addresses
`define PAC_ADDR_CTRL 8'h00
`define PAC_ADDR_OUTSEL 8'h04
`define PAC_ADDR_CHAN_DIV_SELECT 8'h08
`define PAC_ADDR_DEN 8'h0c
`define PAC_ADDR_NUM 8'h10
`define PAC_ADDR_SEED 8'h14
`define PAC_ADDR_ORDER 8'h18
`define PAC_ADDR_STATUS 8'h1c
`define PAC_ADDR_PHASE 8'h20
`define PAC_ADDR_EXTDIV 8'h24

// Control register fields
`define PAC_CTRL_ALIGN_BIT 0
`define PAC_CTRL_DISREGARD_BIT 1
`define PAC_CTRL_FCAL_BIT 2
`define PAC_CTRL_MODRST_BIT 3
`define PAC_CTRL_RESET 4'h2

// Output select encodings
`define PAC_MUX_CHAN_DIV_SELECT 2'h0
`define PAC_MUX_VCO 2'h1
`define PAC_MUX_SYSREF 2'h2

// Channel divider
`define PAC_CHAN_DIV_SELECT_MAX 5'h11
`define PAC_CHAN_DIV_SELECT_DIV2 5'h00

`define PAC_DATA_W 32
`define PAC_ADDR_W 8

`endif

// [pac_extdiv.v]
`timescale 1ns/1ps
`include "pac_defines.vh"

module pac_extdiv (
  input wire [1:0] out_a_select_i,
  input wire [1:0] out_b_select_i,
  input wire [4:0] chan_div_select_i,
  output reg [4:0] extra_div_o,
  output reg [9:0] total_div_o
);

  reg [1:0] stage1;
  reg use_chan_div_select;

  always @* begin
    stage1 = 2'h2;
    total_div_o = 10'h002;
    case (chan_div_select_i)
      5'h00: begin stage1 = 2'h1; total_div_o = 10'h002; end
      5'h01: begin stage1 = 2'h2; total_div_o = 10'h004; end
      5'h02: begin stage1 = 2'h3; total_div_o = 10'h006; end
      5'h03: begin stage1 = 2'h2; total_div_o = 10'h008; end
      5'h04: begin stage1 = 2'h3; total_div_o = 10'h00c; end
      5'h05: begin stage1 = 2'h2; total_div_o = 10'h010; end
      5'h06: begin stage1 = 2'h2; total_div_o = 10'h018; end
      5'h07: begin stage1 = 2'h2; total_div_o = 10'h020; end
      5'h08: begin stage1 = 2'h3; total_div_o = 10'h030; end
      5'h09: begin stage1 = 2'h2; total_div_o = 10'h040; end
      5'h0a: begin stage1 = 2'h3; total_div_o = 10'h048; end
      5'h0b: begin stage1 = 2'h3; total_div_o = 10'h060; end
      5'h0c: begin stage1 = 2'h2; total_div_o = 10'h080; end
      5'h0d: begin stage1 = 2'h2; total_div_o = 10'h0c0; end
      5'h0e: begin stage1 = 2'h2; total_div_o = 10'h100; end
      5'h0f: begin stage1 = 2'h3; total_div_o = 10'h180; end
      5'h10: begin stage1 = 2'h2; total_div_o = 10'h200; end
      5'h11: begin stage1 = 2'h3; total_div_o = 10'h300; end
      default: begin stage1 = 2'h2; total_div_o = 10'h002; end
    endcase
    use_chan_div_select = (out_a_select_i == `PAC_MUX_CHAN_DIV_SELECT) ||
                (out_b_select_i == `PAC_MUX_CHAN_DIV_SELECT) ||
                (out_b_select_i == `PAC_MUX_SYSREF);
    if (!use_chan_div_select) begin
      extra_div_o = 5'h01;
    end else if (chan_div_select_i == `PAC_CHAN_DIV_SELECT_DIV2) begin
      extra_div_o = 5'h04;
    end else begin
      extra_div_o = {2'h0, stage1, 1'b0};
    end
  end

endmodule

// [pac_retime.v]
`timescale 1ns/1ps

module pac_retime (
  input wire clk_i,
  input wire resetn_i,
  input wire req_i,
  input wire ref_rise_i,
  output reg pulse_o
);

  reg pend_r;

  // Hold a request until the next reference rising edge
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pend_r <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= 1'b0;
      if (ref_rise_i && (pend_r || req_i)) begin
        pulse_o <= 1'b1;
        pend_r <= 1'b0;
      end else if (req_i) begin
        pend_r <= 1'b1;
      end
    end
  end

endmodule

// [pac_top_assertions.sv]
`timescale 1ns/1ps
`include "pac_defines.vh"
module pac_chk (
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RESETN_I,
  // Register port
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [31:0] RDATA_O,
  // Reference and results
  input wire REF_INPUT_I,
  input wire ALIGN_PULSE_O,
  input wire CAL_START_O,
  input wire MOD_RESET_O,
  input wire [31:0] PHASE_ACC_O,
  input wire [4:0] EXTRA_DIV_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  sequence mod_rst_wr_s;
    WR_I && ADDR_I == `PAC_ADDR_CTRL && WDATA_I[`PAC_CTRL_MODRST_BIT];
  endsequence
  rdata_idle_zero_a: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data outside read slot");
  extdiv_legal_a: assert property (EXTRA_DIV_O == 5'h1 ||
    EXTRA_DIV_O == 5'h4 || EXTRA_DIV_O == 5'h6)
    else $error("illegal extra divide");
  cal_with_align_a: assert property (CAL_START_O |->
    ALIGN_PULSE_O) else $error("calibration without alignment");
  align_single_a: assert property (ALIGN_PULSE_O |=>
    !ALIGN_PULSE_O) else $error("alignment pulse too long");
  align_after_ref_a: assert property (ALIGN_PULSE_O |->
    $past(REF_INPUT_I, 2) && !$past(REF_INPUT_I, 3))
    else $error("alignment not retimed");
  mod_rst_pulse_a: assert property (mod_rst_wr_s |->
    ##2 MOD_RESET_O) else $error("modulator reset missing");
  acc_clear_a: assert property ((ALIGN_PULSE_O || MOD_RESET_O) |->
    ##[0:2] PHASE_ACC_O == 32'h0) else $error("phase not cleared");
  acc_seed_only_a: assert property ($changed(PHASE_ACC_O) &&
    PHASE_ACC_O != 32'h0 |-> $past(WR_I, 2) &&
    $past(ADDR_I, 2) == `PAC_ADDR_SEED) else $error("phase moved alone");
endmodule
bind pac_top pac_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .REF_INPUT_I(REF_INPUT_I),
  .ALIGN_PULSE_O(ALIGN_PULSE_O), .CAL_START_O(CAL_START_O),
  .MOD_RESET_O(MOD_RESET_O), .PHASE_ACC_O(PHASE_ACC_O),
  .EXTRA_DIV_O(EXTRA_DIV_O));

// [pac_host.sv]
`timescale 1ns/1ps
module pac_host (
  // Bench command
  input wire pin_req_i,
  // Pins toward device
  output reg ref_o,
  output reg pin_o
);
  initial begin
    ref_o = 1'b0;
    pin_o = 1'b0;
  end
  // Free-running reference whose edges never meet a rising system edge
  always #21.2 ref_o = ~ref_o;
  // Host never aligns category 4 setups
  // Host keeps the feedback integer above the order minimum
  // Calibration codes are left free, not forced, in this model
  // Pin rise replaces the bit write
  // Pin edge mid low phase, away from reference rise
  always @(posedge pin_req_i) begin
    @(negedge ref_o);
    #10 pin_o = 1'b1;
    #60 pin_o = 1'b0;
  end
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "pac_defines.vh"
module tb;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg pin_req = 1'b0;
  wire ref_in, pin, apulse, cal, modrst;
  wire [31:0] rdata, acc, step;
  wire [4:0] xdiv;
  integer err_count = 0;
  integer tests_run = 0;
  integer pcnt = 0;
  integer ccnt = 0;
  integer mcnt = 0;
  integer i;
  reg [31:0] rv;
  reg [31:0] sel;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (apulse === 1'b1) pcnt = pcnt + 1;
    if (cal === 1'b1) ccnt = ccnt + 1;
    if (modrst === 1'b1) mcnt = mcnt + 1;
  end
  pac_host u_host (.pin_req_i(pin_req), .ref_o(ref_in), .pin_o(pin));
  pac_top u_dut (.CLK_SYS_I(clk), .RESETN_I(rstn), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .REF_INPUT_I(ref_in), .ALIGN_PIN_I(pin), .ALIGN_PULSE_O(apulse),
    .CAL_START_O(cal), .MOD_RESET_O(modrst), .PHASE_ACC_O(acc),
    .PHASE_STEP_O(step), .EXTRA_DIV_O(xdiv));
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task pin_pulse;
    begin
      @(posedge clk);
      pin_req <= 1'b1;
      @(posedge clk);
      pin_req <= 1'b0;
      idle(40);
    end
  endtask
  task chk32(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        err_count = err_count + 1;
      end
    end
  endtask
  function [31:0] xd(input [31:0] s, input integer c);
    begin
      if (s[1:0] != 2'h0 && s[5:4] != 2'h0 && s[5:4] != 2'h2) xd = 32'h1;
      else if (c == 2 || c == 4 || c == 8 || c == 10 || c == 11 ||
        c == 15 || c == 17) xd = 32'h6;
      else xd = 32'h4;
    end
  endfunction
  task print_verdict;
    begin
      if (err_count == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    err_count = err_count + 1;
    print_verdict;
  end
  initial begin
    idle(8);
    rstn <= 1'b1;
    rd_reg(`PAC_ADDR_CTRL);
    chk32(rv, 32'h2);
    rd_reg(`PAC_ADDR_DEN);
    chk32(rv, 32'h1);
    rd_reg(8'h3c);
    chk32(rv, 32'h0);
    chk32(xdiv, 32'h1);
    for (i = 0; i < 18; i = i + 1) begin
      sel = (i % 5 == 0) ? 32'h10 : (i % 5 == 1) ? 32'h21 :
        (i % 5 == 2) ? 32'h01 : (i % 5 == 3) ? 32'h11 : 32'h12;
      wr_reg(`PAC_ADDR_CHAN_DIV_SELECT, i);
      wr_reg(`PAC_ADDR_OUTSEL, sel);
      idle(1);
      chk32(xdiv, xd(sel, i));
    end
    wr_reg(`PAC_ADDR_CHAN_DIV_SELECT, 32'h12);
    rd_reg(`PAC_ADDR_CHAN_DIV_SELECT);
    chk32(rv, 32'h300);
    wr_reg(`PAC_ADDR_OUTSEL, 32'h10);
    wr_reg(`PAC_ADDR_CHAN_DIV_SELECT, 32'h5);
    wr_reg(`PAC_ADDR_DEN, 32'hc);
    wr_reg(`PAC_ADDR_NUM, 32'h7);
    rd_reg(`PAC_ADDR_NUM);
    chk32(rv, 32'h7);
    wr_reg(`PAC_ADDR_NUM, 32'h0);
    wr_reg(`PAC_ADDR_ORDER, 32'h2);
    wr_reg(`PAC_ADDR_SEED, 32'h1);
    idle(3);
    chk32(acc, 32'h4);
    wr_reg(`PAC_ADDR_SEED, 32'h3);
    idle(3);
    chk32(acc, 32'h10);
    chk32(step, 32'hc);
    wr_reg(`PAC_ADDR_CTRL, 32'ha);
    idle(3);
    chk32(acc, 32'h0);
    chk32(mcnt, 32'h1);
    wr_reg(`PAC_ADDR_ORDER, 32'h0);
    wr_reg(`PAC_ADDR_SEED, 32'h1);
    idle(3);
    chk32(acc, 32'h0);
    wr_reg(`PAC_ADDR_ORDER, 32'h1);
    wr_reg(`PAC_ADDR_SEED, 32'h5);
    idle(3);
    chk32(acc, 32'h0);
    wr_reg(`PAC_ADDR_SEED, 32'hc);
    idle(3);
    chk32(acc, 32'h30);
    rd_reg(`PAC_ADDR_PHASE);
    chk32(rv, 32'h30);
    rd_reg(`PAC_ADDR_STATUS);
    chk32(rv, 32'h5);
    rd_reg(`PAC_ADDR_EXTDIV);
    chk32(rv, 32'h4);
    wr_reg(`PAC_ADDR_CTRL, 32'h5);
    idle(30);
    chk32(pcnt, 32'h1);
    chk32(ccnt, 32'h1);
    chk32(acc, 32'h0);
    wr_reg(`PAC_ADDR_CTRL, 32'h5);
    idle(30);
    chk32(pcnt, 32'h1);
    pin_pulse;
    chk32(pcnt, 32'h2);
    chk32(ccnt, 32'h2);
    wr_reg(`PAC_ADDR_CTRL, 32'h1);
    pin_pulse;
    chk32(pcnt, 32'h2);
    wr_reg(`PAC_ADDR_CTRL, 32'h7);
    pin_pulse;
    chk32(pcnt, 32'h2);
    wr_reg(`PAC_ADDR_CTRL, 32'h6);
    idle(4);
    print_verdict;
  end
endmodule
